/* qdc_pkg.sv */
package qdc_pkg;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 16;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int ADDR_W = 4;
  localparam int POS_RW = 23;
  localparam int POS_ADDR_HI = 22;
  localparam int POS_ADDR_LO = 19;
  localparam int POS_DATA_HI = 18;
  localparam int POS_DATA_LO = 3;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_MON = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO0 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_GAIN0 = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_DATA0 = 4'hc;
  localparam int CMD_LD_BIT = 14;
  localparam int CMD_RST_BIT = 15;
  localparam int CMD_GAIN_LO = 2;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] TRIM_RESET = 16'h0000;
  localparam logic [NUM_CH-1:0] GAIN_SEL_RESET = 4'hf;
  localparam logic [CODE_W-1:0] GAIN_TRIM_MIN = 16'hff80;
  localparam logic [CODE_W-1:0] GAIN_TRIM_MAX = 16'h007f;
  localparam logic [CODE_W-1:0] ZERO_TRIM_MIN = 16'hff00;
  localparam logic [CODE_W-1:0] ZERO_TRIM_MAX = 16'h00ff;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } qdc_serial_t;
  typedef struct packed {
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] data;
  } qdc_frame_t;
endpackage

/* qdc_sync.sv */
module qdc_sync
  import qdc_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
)
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

/* qdc_update_ctrl.sv */
module qdc_update_ctrl
  import qdc_pkg::*;
#(
  parameter int NCH = NUM_CH
)
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic hw_reset_n_in,
  input wire logic latch_load_n_in,
  input wire logic group_a_polarity_sel_in,
  input wire logic group_b_polarity_sel_in,
  input wire qdc_serial_t serial_in,
  output logic sdo_out,
  output logic [NCH*CODE_W-1:0] latch_code_out,
  output logic [NCH-1:0] unipolar_out,
  output logic [NCH-1:0] gain4_sel_out,
  output logic [NCH*CODE_W-1:0] gain_trim_out,
  output logic [NCH*CODE_W-1:0] zero_trim_out,
  output logic [NCH-1:0] pending_out
);

////////////////////////////////////////////////////////////////////////////
  logic [1:0] pins_sync;
  logic load_n_s;
  logic hw_rst_n_s;

  qdc_sync #(.WIDTH(2), .INIT(2'h3)) u_sync
  (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({latch_load_n_in, hw_reset_n_in}),
    .sync_out(pins_sync)
  );
  assign load_n_s = pins_sync[1];
  assign hw_rst_n_s = pins_sync[0];
  typedef enum {QDC_IDLE, QDC_SHIFT} qdc_state_t;
////////////////////////////////////////////////////////////////////////////
  // Serial pins sampled once per core clock
  logic sclk_reg, sclk_next;
  logic cs_n_reg, cs_n_next;
  logic load_n_reg, load_n_next;
  logic soft_rst_reg, soft_rst_next;
  qdc_state_t state_reg, state_next;
  logic [FRAME_BITS-1:0] shift_reg, shift_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [FRAME_BITS-1:0] rdbk_reg, rdbk_next;
  logic [CODE_W-1:0] rd_word;
  logic [NCH-1:0] uni_reg, uni_next;
  logic [CODE_W-1:0] in_code_reg [NCH];
  logic [CODE_W-1:0] in_code_next [NCH];
  logic [CODE_W-1:0] latch_reg [NCH];
  logic [CODE_W-1:0] latch_next [NCH];
  logic [CODE_W-1:0] gtrim_reg [NCH];
  logic [CODE_W-1:0] gtrim_next [NCH];
  logic [CODE_W-1:0] ztrim_reg [NCH];
  logic [CODE_W-1:0] ztrim_next [NCH];
  logic [CODE_W-1:0] cmd_reg, cmd_next;
  logic [CODE_W-1:0] mon_reg, mon_next;
  logic [NCH-1:0] written_reg, written_next;
  logic in_reset;
  logic sclk_fall;
  logic cs_rise;
  logic frame_ok;
  logic load_fall;
  logic ld_bit_wr;
  logic data_wr;
  logic [NCH-1:0] ch_wr;
  logic [NCH-1:0] ch_reload;
  qdc_frame_t frame;
  assign in_reset = !hw_rst_n_s || soft_rst_reg;
  assign sclk_fall = sclk_reg && !serial_in.sclk && !serial_in.cs_n;
  assign cs_rise = !cs_n_reg && serial_in.cs_n;
  assign frame_ok = cs_rise && (state_reg == QDC_SHIFT) && (cnt_reg == CNT_W'(FRAME_BITS));
  assign frame = qdc_frame_t'({shift_reg[POS_RW], shift_reg[POS_ADDR_HI:POS_ADDR_LO],
                               shift_reg[POS_DATA_HI:POS_DATA_LO]});
  assign data_wr = frame_ok && !frame.rw;
  assign ld_bit_wr = data_wr && (frame.addr == ADDR_CMD) && frame.data[CMD_LD_BIT];
  assign load_fall = load_n_reg && !load_n_s;
  function automatic logic [CODE_W-1:0] clamp(input logic [CODE_W-1:0] v,
                                               input logic [CODE_W-1:0] lo,
                                               input logic [CODE_W-1:0] hi);
    if ($signed(v) < $signed(lo))
      return lo;
    else if ($signed(v) > $signed(hi))
      return hi;
    else
      return v;
  endfunction
////////////////////////////////////////////////////////////////////////////
  // Shift engine
  always_comb
  begin
    sclk_next = serial_in.sclk;
    cs_n_next = serial_in.cs_n;
    load_n_next = load_n_s;
    state_next = state_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    rdbk_next = rdbk_reg;
    if (in_reset)
    begin
      state_next = QDC_IDLE;
      cnt_next = '0;
    end
    else
    begin
      case (state_reg)
        QDC_IDLE:
        begin
          if (cs_n_reg && !serial_in.cs_n)
          begin
            state_next = QDC_SHIFT;
            cnt_next = '0;
          end
        end
        QDC_SHIFT:
        begin
          if (serial_in.cs_n)
            state_next = QDC_IDLE;
          else if (sclk_fall)
          begin
            shift_next = {shift_reg[FRAME_BITS-2:0], serial_in.sdi};
            rdbk_next = {rdbk_reg[FRAME_BITS-2:0], 1'b0};
            if (cnt_reg != CNT_W'(FRAME_BITS))
              cnt_next = cnt_reg + 1'b1;
          end
        end
        default:
          state_next = QDC_IDLE;
      endcase
      if (frame_ok && frame.rw)
        rdbk_next = {frame.rw, frame.addr, rd_word, 3'h0};
    end
  end
  // Readback source: same format that was written
  always_comb
  begin
    rd_word = '0;
    if (frame.addr == ADDR_CMD)
      rd_word = cmd_reg;
    else if (frame.addr == ADDR_MON)
      rd_word = mon_reg;
    for (int i = 0; i < NCH; i++)
    begin
      if (frame.addr == ADDR_ZERO0 + ADDR_W'(i))
        rd_word = ztrim_reg[i];
      if (frame.addr == ADDR_GAIN0 + ADDR_W'(i))
        rd_word = gtrim_reg[i];
      if (frame.addr == ADDR_DATA0 + ADDR_W'(i))
        rd_word = in_code_reg[i];
    end
  end
////////////////////////////////////////////////////////////////////////////
  // Register bank, update and reset
  always_comb
  begin
    cmd_next = cmd_reg;
    mon_next = mon_reg;
    soft_rst_next = 1'b0;
    written_next = written_reg;
    ch_wr = '0;
    ch_reload = '0;
    for (int i = 0; i < NCH; i++)
    begin
      in_code_next[i] = in_code_reg[i];
      latch_next[i] = latch_reg[i];
      gtrim_next[i] = gtrim_reg[i];
      ztrim_next[i] = ztrim_reg[i];
    end
    if (in_reset)
    begin
      cmd_next = {CODE_W'(GAIN_SEL_RESET) << CMD_GAIN_LO};
      mon_next = '0;
      written_next = '0;
      for (int i = 0; i < NCH; i++)
      begin
        in_code_next[i] = CODE_RESET;
        latch_next[i] = CODE_RESET;
        gtrim_next[i] = TRIM_RESET;
        ztrim_next[i] = TRIM_RESET;
      end
    end
    else
    begin
      if (data_wr)
      begin
        if (frame.addr == ADDR_CMD)
        begin
          cmd_next = frame.data;
          cmd_next[CMD_LD_BIT] = 1'b0;
          cmd_next[CMD_RST_BIT] = 1'b0;
          soft_rst_next = frame.data[CMD_RST_BIT];
        end
        if (frame.addr == ADDR_MON)
          mon_next = frame.data;
        for (int i = 0; i < NCH; i++)
        begin
          if (frame.addr == ADDR_GAIN0 + ADDR_W'(i))
            gtrim_next[i] = clamp(frame.data, GAIN_TRIM_MIN, GAIN_TRIM_MAX);
          if (frame.addr == ADDR_ZERO0 + ADDR_W'(i))
            ztrim_next[i] = clamp(frame.data, ZERO_TRIM_MIN, ZERO_TRIM_MAX);
          if (frame.addr == ADDR_DATA0 + ADDR_W'(i))
          begin
            ch_wr[i] = 1'b1;
            in_code_next[i] = frame.data;
          end
        end
      end
      for (int i = 0; i < NCH; i++)
      begin
        // Individual update when load pin low, group update on load event
        if (ch_wr[i] && !load_n_s)
          ch_reload[i] = 1'b1;
        else if ((load_fall || ld_bit_wr) && written_reg[i])
          ch_reload[i] = 1'b1;
        if (ch_reload[i])
        begin
          latch_next[i] = ch_wr[i] ? frame.data : in_code_reg[i];
          written_next[i] = 1'b0;
        end
        else if (ch_wr[i])
          written_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      load_n_reg <= 1'b1;
      soft_rst_reg <= 1'b0;
      state_reg <= QDC_IDLE;
      shift_reg <= '0;
      cnt_reg <= '0;
      rdbk_reg <= '0;
      uni_reg <= '0;
      cmd_reg <= CODE_W'(GAIN_SEL_RESET) << CMD_GAIN_LO;
      mon_reg <= '0;
      written_reg <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        in_code_reg[i] <= CODE_RESET;
        latch_reg[i] <= CODE_RESET;
        gtrim_reg[i] <= TRIM_RESET;
        ztrim_reg[i] <= TRIM_RESET;
      end
    end
    else
    begin
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      load_n_reg <= load_n_next;
      soft_rst_reg <= soft_rst_next;
      state_reg <= state_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      rdbk_reg <= rdbk_next;
      uni_reg <= uni_next;
      cmd_reg <= cmd_next;
      mon_reg <= mon_next;
      written_reg <= written_next;
      for (int i = 0; i < NCH; i++)
      begin
        in_code_reg[i] <= in_code_next[i];
        latch_reg[i] <= latch_next[i];
        gtrim_reg[i] <= gtrim_next[i];
        ztrim_reg[i] <= ztrim_next[i];
      end
    end
  end
////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      assign latch_code_out[g*CODE_W +: CODE_W] = latch_reg[g];
      assign gain_trim_out[g*CODE_W +: CODE_W] = gtrim_reg[g];
      assign zero_trim_out[g*CODE_W +: CODE_W] = ztrim_reg[g];
      assign gain4_sel_out[g] = cmd_reg[CMD_GAIN_LO + g];
      assign uni_next[g] = (g < 2) ? group_a_polarity_sel_in : group_b_polarity_sel_in;
    end
  endgenerate
  assign unipolar_out = uni_reg;
  assign pending_out = written_reg;
  assign sdo_out = rdbk_reg[FRAME_BITS-1];
////////////////////////////////////////////////////////////////////////////
  property p_short_frame;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!in_reset && !load_fall && cs_rise && cnt_reg != CNT_W'(FRAME_BITS)) |=>
      ($stable(written_reg) && $stable(in_code_reg[0]));
  endproperty
  a_short_frame: assert property (p_short_frame) else $error("short frame changed state");
  property p_reset_latch;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    in_reset |=> (latch_reg[0] == CODE_RESET && written_reg == '0);
  endproperty
  a_reset_latch: assert property (p_reset_latch) else $error("reset did not clear");
  property p_soft_clear;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    soft_rst_reg |=> !soft_rst_reg;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset stuck");
  property p_gain_reset;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    in_reset |=> gain4_sel_out == GAIN_SEL_RESET;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain bits not set");
  property p_indiv;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!in_reset && ch_wr[3] && !load_n_s) |=> latch_reg[3] == in_code_reg[3];
  endproperty
  a_indiv: assert property (p_indiv) else $error("individual update missed");
  property p_hold;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!in_reset && ch_wr[1] && load_n_s && !load_fall && !ld_bit_wr) |=>
      ($stable(latch_reg[1]) && written_reg[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed on buffered write");
  property p_unwritten;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!in_reset && load_fall && !written_reg[2] && !ch_wr[2]) |=> $stable(latch_reg[2]);
  endproperty
  a_unwritten: assert property (p_unwritten) else $error("unwritten latch reloaded");
  property p_gtrim;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    ($signed(gtrim_reg[0]) <= $signed(GAIN_TRIM_MAX)) &&
    ($signed(gtrim_reg[0]) >= $signed(GAIN_TRIM_MIN));
  endproperty
  a_gtrim: assert property (p_gtrim) else $error("gain trim out of range");
  property p_load_event;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    (!in_reset && load_fall && written_reg[0] && !ch_wr[0]) |=>
      (latch_reg[0] == $past(in_code_reg[0]) && !written_reg[0]);
  endproperty
  a_load_event: assert property (p_load_event) else $error("load event missed");
endmodule

/* qdc_host_model.sv */
module qdc_host_model
  import qdc_pkg::*;
#(
  parameter int PHASE = 3
)
(
  input wire logic core_clk_in,
  input wire logic sdo_in,
  output qdc_serial_t serial_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    serial_out = '{cs_n: 1'b1, sclk: 1'b1, sdi: 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame, MSB first, clock idles high so first edge falls
  task automatic xfer(input logic [23:0] word, input int nbits, output logic [23:0] rd);
    rd = '0;
    @(posedge core_clk_in);
    #1;
    serial_out.cs_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      serial_out.sdi = word[23-i];
      repeat (PHASE) @(posedge core_clk_in);
      #1;
      rd = {rd[22:0], sdo_in};
      serial_out.sclk = 1'b0;
      repeat (PHASE) @(posedge core_clk_in);
      #1;
      serial_out.sclk = 1'b1;
    end
    repeat (PHASE) @(posedge core_clk_in);
    #1;
    serial_out.cs_n = 1'b1;
    // Stale data line flips once released
    serial_out.sdi = ~serial_out.sdi;
  endtask
endmodule

/* quad_dac_update_reset_control_tb.sv */
module quad_dac_update_reset_control_tb;
  import qdc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [63:0] latch;
    logic [63:0] gtrim;
    logic [63:0] ztrim;
    logic [3:0] gain4;
    logic [3:0] pend;
    logic [3:0] uni;
    logic [15:0] rd;
    logic chk_rd;
  } qdc_exp_t;

  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hw_reset_n = 1'b1;
  logic latch_load_n = 1'b1;
  logic group_a_polarity_sel = 1'b0;
  logic group_b_polarity_sel = 1'b0;
  qdc_serial_t serial;
  logic sdo;
  logic [63:0] latch_code;
  logic [63:0] gain_trim;
  logic [63:0] zero_trim;
  logic [3:0] unipolar;
  logic [3:0] gain4_sel;
  logic [3:0] pending;
  logic chk_req = 1'b0;
  int mismatches = 0;
  int total_checks = 0;
  qdc_exp_t exp_q[$];
  qdc_exp_t w_e;
  logic [15:0] m_code[4];
  logic [15:0] m_latch[4];
  logic [15:0] m_gt[4];
  logic [15:0] m_zt[4];
  logic [15:0] vals[4] = '{16'h0100, 16'hfe00, 16'h0080, 16'hff7f};
  logic [3:0] m_gain4;
  logic [3:0] m_pend;
  logic [23:0] rd_word;
  logic [15:0] rd_exp = '0;
  logic rd_chk = 1'b0;

  always #20 core_clk_in = ~core_clk_in;

  qdc_update_ctrl DUT (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .hw_reset_n_in(hw_reset_n),
    .latch_load_n_in(latch_load_n),
    .group_a_polarity_sel_in(group_a_polarity_sel),
    .group_b_polarity_sel_in(group_b_polarity_sel),
    .serial_in(serial),
    .sdo_out(sdo),
    .latch_code_out(latch_code),
    .unipolar_out(unipolar),
    .gain4_sel_out(gain4_sel),
    .gain_trim_out(gain_trim),
    .zero_trim_out(zero_trim),
    .pending_out(pending)
  );

  qdc_host_model host (
    .core_clk_in(core_clk_in),
    .sdo_in(sdo),
    .serial_out(serial)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] want);
    total_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if ($signed(v) < $signed(lo))
      return lo;
    if ($signed(v) > $signed(hi))
      return hi;
    return v;
  endfunction

  task automatic model_reset();
    m_code = '{default: CODE_RESET};
    m_latch = '{default: CODE_RESET};
    m_gt = '{default: TRIM_RESET};
    m_zt = '{default: TRIM_RESET};
    m_gain4 = GAIN_SEL_RESET;
    m_pend = '0;
  endtask

  task automatic load_pending();
    for (int c = 0; c < 4; c++)
      if (m_pend[c])
        m_latch[c] = m_code[c];
    m_pend = '0;
  endtask

  task automatic expect_now(input string name);
    qdc_exp_t e;
    for (int c = 0; c < 4; c++)
    begin
      e.latch[c*16 +: 16] = m_latch[c];
      e.gtrim[c*16 +: 16] = m_gt[c];
      e.ztrim[c*16 +: 16] = m_zt[c];
    end
    e.gain4 = m_gain4;
    e.pend = m_pend;
    e.uni = {{2{group_b_polarity_sel}}, {2{group_a_polarity_sel}}};
    e.rd = rd_exp;
    e.chk_rd = rd_chk;
    exp_q.push_back(e);
    chk_req = 1'b1;
    cyc(1);
    chk_req = 1'b0;
    rd_chk = 1'b0;
    $display("test %s done", name);
  endtask

  // Frame plus model update
  task automatic xfer(input logic rw, input logic [3:0] addr, input logic [15:0] data,
                      input int nb);
    int ch;
    host.xfer({rw, addr, data, 3'b000}, nb, rd_word);
    cyc(6);
    if (nb != 24 || rw || hw_reset_n !== 1'b1)
      return;
    ch = addr[1:0];
    case (addr[3:2])
      2'b11:
      begin
        m_code[ch] = data;
        m_pend[ch] = 1'b1;
        if (latch_load_n === 1'b0)
          load_pending();
      end
      2'b10: m_gt[ch] = clamp(data, GAIN_TRIM_MIN, GAIN_TRIM_MAX);
      2'b01: m_zt[ch] = clamp(data, ZERO_TRIM_MIN, ZERO_TRIM_MAX);
      default:
      begin
        if (addr == ADDR_CMD)
        begin
          m_gain4 = data[CMD_GAIN_LO +: 4];
          if (data[CMD_RST_BIT])
            model_reset();
          else if (data[CMD_LD_BIT])
            load_pending();
        end
      end
    endcase
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in)
  begin
    if (chk_req)
    begin
      if (exp_q.size() == 0)
        cmp(64'h0, 64'h1);
      else
      begin
        w_e = exp_q.pop_front();
        cmp(latch_code, w_e.latch);
        cmp(gain_trim, w_e.gtrim);
        cmp(zero_trim, w_e.ztrim);
        cmp(64'(gain4_sel), 64'(w_e.gain4));
        cmp(64'(pending), 64'(w_e.pend));
        cmp(64'(unipolar), 64'(w_e.uni));
        if (w_e.chk_rd)
          cmp(64'(rd_word[18:3]), 64'(w_e.rd));
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    mismatches++;
    complete_run();
  end

  initial
  begin
    void'($urandom(32'h0779));
    model_reset();
    cyc(10);
    rst_n_in = 1'b1;
    cyc(4);
    expect_now("defaults");
    for (int p = 0; p < 4; p++)
    begin
      {group_b_polarity_sel, group_a_polarity_sel} = p[1:0];
      cyc(1);
      expect_now("polarity");
    end
    xfer(1'b0, ADDR_DATA0, 16'($urandom), 24);
    xfer(1'b0, ADDR_DATA0 | 4'h2, 16'($urandom), 24);
    expect_now("buffered write");
    latch_load_n = 1'b0;
    cyc(6);
    load_pending();
    expect_now("load pin");
    latch_load_n = 1'b1;
    cyc(4);
    xfer(1'b0, ADDR_DATA0 | 4'h1, 16'($urandom), 24);
    xfer(1'b0, ADDR_CMD, 16'h4014, 24);
    expect_now("load bit");
    // Host holds load low across the whole write
    latch_load_n = 1'b0;
    cyc(6);
    xfer(1'b0, ADDR_DATA0 | 4'h3, 16'($urandom), 24);
    latch_load_n = 1'b1;
    expect_now("direct update");
    xfer(1'b0, ADDR_DATA0, 16'hffff, 23);
    expect_now("short frame");
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, ADDR_GAIN0 | 4'(i), vals[i], 24);
      xfer(1'b0, ADDR_ZERO0 | 4'(i), vals[i], 24);
    end
    expect_now("trim limits");
    xfer(1'b1, ADDR_GAIN0 | 4'h1, 16'h0000, 24);
    xfer(1'b1, ADDR_GAIN0 | 4'h1, 16'h0000, 24);
    rd_exp = m_gt[1];
    rd_chk = 1'b1;
    expect_now("readback");
    rd_exp = 16'($urandom);
    xfer(1'b0, ADDR_MON, rd_exp, 24);
    xfer(1'b1, ADDR_MON, 16'h0000, 24);
    xfer(1'b1, ADDR_CMD, 16'h0000, 24);
    rd_chk = 1'b1;
    expect_now("monitor readback");
    hw_reset_n = 1'b0;
    cyc(6);
    model_reset();
    xfer(1'b0, ADDR_DATA0, 16'h1234, 24);
    hw_reset_n = 1'b1;
    cyc(6);
    expect_now("hardware reset");
    xfer(1'b0, ADDR_DATA0 | 4'h2, 16'($urandom), 24);
    xfer(1'b0, ADDR_CMD, 16'h0000, 24);
    expect_now("gain clear");
    xfer(1'b0, ADDR_CMD, 16'h8000, 24);
    cyc(2);
    expect_now("soft reset");
    complete_run();
  end
endmodule
